//--- gpio_port_pkg.sv
package gpio_port_pkg;

  localparam int NUM_LINES = 7;
  localparam int FUNC_W    = 3;

  typedef logic [FUNC_W-1:0] func_sel_t;
  typedef logic [NUM_LINES-1:0] line_vec_t;

  // Per-line function codes; code zero is the general-purpose function.
  localparam func_sel_t FN_GPIO = 3'h0;
  localparam func_sel_t FN_ALT1 = 3'h1;
  localparam func_sel_t FN_ALT2 = 3'h2;
  localparam func_sel_t FN_ALT3 = 3'h3;
  localparam func_sel_t FN_ALT4 = 3'h4;

  // Lines 0..3 sit in selection word A, lines 4..6 in word B.
  localparam int SEL_A_LINES = 4;
  localparam int SEL_B_LINES = 3;

  localparam line_vec_t OUT_RESET     = 7'h00;
  localparam line_vec_t STATUS_RESET  = 7'h00;
  // Lines 2 and 4 live on the I/O supply only and cannot switch the device on.
  localparam line_vec_t ON_REQ_CAPABLE = 7'h6B;

  localparam int CLK_PERIOD_NS    = 10;
  localparam int DEBOUNCE_TIME_NS = 1000;
  localparam int DEBOUNCE_CYCLES  = (DEBOUNCE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int DEB_CNT_W        = 8;

  typedef enum logic [0:0] {
    DEB_STABLE   = 1'b0,
    DEB_COUNTING = 1'b1
  } deb_state_t;

endpackage : gpio_port_pkg

//--- line_debounce.sv
`timescale 1ns/1ps

module line_debounce
  import gpio_port_pkg::*;
#(
  parameter int CYCLES = DEBOUNCE_CYCLES
)
(
  input  wire logic core_clk_i,
  input  wire logic reset_i,
  input  wire logic raw_i,
  input  wire logic enable_i,
  output logic      level_o
);

  deb_state_t           state_q;
  logic [DEB_CNT_W-1:0] count_q;
  logic                 level_q;

  assign level_o = level_q;

  // A change is accepted only after it has held for the full debounce time.
  always_ff @(posedge core_clk_i)
  begin
    if (reset_i)
    begin
      state_q <= DEB_STABLE;
      count_q <= '0;
      level_q <= 1'b0;
    end
    else if (!enable_i)
    begin
      state_q <= DEB_STABLE;
      count_q <= '0;
      level_q <= raw_i;
    end
    else
    begin
      unique case (state_q)
        DEB_STABLE:
        begin
          count_q <= '0;
          if (raw_i != level_q)
          begin
            state_q <= DEB_COUNTING;
          end
        end
        DEB_COUNTING:
        begin
          if (raw_i == level_q)
          begin
            state_q <= DEB_STABLE;
          end
          else if (count_q == DEB_CNT_W'(CYCLES - 1))
          begin
            level_q <= raw_i;
            state_q <= DEB_STABLE;
          end
          else
          begin
            count_q <= count_q + 1'b1;
          end
        end
      endcase
    end
  end

endmodule : line_debounce

//--- line_event.sv
`timescale 1ns/1ps

module line_event
  import gpio_port_pkg::*;
(
  input  wire logic core_clk_i,
  input  wire logic reset_i,
  input  wire logic level_i,
  input  wire logic rise_en_i,
  input  wire logic fall_en_i,
  input  wire logic arm_i,
  input  wire logic clear_i,
  output logic      event_o,
  output logic      status_o
);

  logic prev_q;
  logic status_q;
  logic edge_hit;

  assign edge_hit = (level_i & ~prev_q & rise_en_i) | (~level_i & prev_q & fall_en_i);
  assign event_o  = edge_hit & arm_i;
  assign status_o = status_q;

  always_ff @(posedge core_clk_i)
  begin
    if (reset_i)
    begin
      prev_q <= 1'b0;
    end
    else
    begin
      prev_q <= level_i;
    end
  end

  // A new event wins over a clear in the same cycle.
  always_ff @(posedge core_clk_i)
  begin
    if (reset_i)
    begin
      status_q <= 1'b0;
    end
    else if (event_o)
    begin
      status_q <= 1'b1;
    end
    else if (clear_i)
    begin
      status_q <= 1'b0;
    end
  end

endmodule : line_event

//--- pmic_gpio_mux_port.sv
`timescale 1ns/1ps

// Overview of operation
// - Seven pads, each general-purpose or one of several alternate functions.
// - Line 0 alternates: power-off input, peripheral request 2 input, regulator 1 output.
// - Line 1 alternates: reset, warm reset, bus-supply detect, peripheral request 1 inputs.
// - Line 2 alternates: scaling-port data (bidirectional) or peripheral request 2 input.
// - Line 3 alternates: regulator 1 enable output or converter clock sync input.
// - Line 4 alternates: regulator 2 enable output or scaling-port clock/select.
// - Line 5 alternates: keep-alive input or regulator 3 enable output.
// - Line 6 alternates: sleep request input, supplies-valid output, regulator 3 output.
// - Per-line interrupt on rising, falling or both edges, individually maskable.
// - Only lines in general-purpose mode raise port interrupts.
// - Wake events come from the same armed edges as interrupts; lines 2 and 4 never switch on from off.
// - Regulator enable outputs follow the external regulator-on inputs.
// - Two selection words choose each line's function.
// - Direction control sets each line input or output.
// - Input readback returns sampled level of general-purpose lines set as input.
// - Output register holds the level driven on output lines.
// - Debounce enable per line.
// - Global enable turns all general-purpose lines on or off.
// - Separate set and clear strobes modify output register bits.
// - Two pull configuration words give pull-up and pull-down per line.
// - Open-drain enable per line.
// - Alternate mode ignores general-purpose controls; own pull and open-drain set.
// - Masked lines detect no events; nothing is recorded or signalled.

module pmic_gpio_mux_port
  import gpio_port_pkg::*;
#(
  parameter int LINES      = NUM_LINES,
  parameter int DEB_CYCLES = DEBOUNCE_CYCLES
)
(
  input  wire logic                          core_clk_i,
  input  wire logic                          reset_i,
  input  wire logic [LINES-1:0]              pad_in_i,
  output logic      [LINES-1:0]              pad_out_o,
  output logic      [LINES-1:0]              pad_oe_o,
  output logic      [LINES-1:0]              pad_pull_up_o,
  output logic      [LINES-1:0]              pad_pull_down_o,
  input  wire logic [SEL_A_LINES*FUNC_W-1:0] pad_function_select_a_i,
  input  wire logic [SEL_B_LINES*FUNC_W-1:0] pad_function_select_b_i,
  input  wire logic                          gpio_global_enable_i,
  input  wire logic [LINES-1:0]              line_direction_i,
  input  wire logic [LINES-1:0]              line_debounce_enable_i,
  input  wire logic [LINES-1:0]              line_pull_config_a_i,
  input  wire logic [LINES-1:0]              line_pull_config_b_i,
  input  wire logic [LINES-1:0]              line_open_drain_enable_i,
  input  wire logic [LINES-1:0]              alt_pull_up_i,
  input  wire logic [LINES-1:0]              alt_pull_down_i,
  input  wire logic [LINES-1:0]              alt_open_drain_i,
  input  wire logic                          out_write_i,
  input  wire logic [LINES-1:0]              out_wdata_i,
  input  wire logic                          out_set_i,
  input  wire logic [LINES-1:0]              out_set_bits_i,
  input  wire logic                          out_clear_i,
  input  wire logic [LINES-1:0]              out_clear_bits_i,
  output logic      [LINES-1:0]              line_data_out_o,
  output logic      [LINES-1:0]              line_data_in_o,
  input  wire logic [LINES-1:0]              edge_rise_en_i,
  input  wire logic [LINES-1:0]              edge_fall_en_i,
  input  wire logic [LINES-1:0]              irq_mask_i,
  input  wire logic [LINES-1:0]              irq_clear_i,
  output logic      [LINES-1:0]              irq_status_o,
  output logic                               irq_o,
  output logic      [LINES-1:0]              wake_event_o,
  output logic      [LINES-1:0]              on_request_o,
  input  wire logic                          ext_regulator_on_1_i,
  input  wire logic                          ext_regulator_on_2_i,
  input  wire logic                          ext_regulator_on_3_i,
  input  wire logic                          supplies_valid_out_i,
  input  wire logic                          scaling_port_data_out_i,
  input  wire logic                          scaling_port_data_oe_i,
  output logic                               scaling_port_data_in_o,
  input  wire logic                          scaling_port_clock_select_out_i,
  input  wire logic                          scaling_port_clock_select_oe_i,
  output logic                               scaling_port_clock_select_in_o,
  output logic                               power_off_request_in_o,
  output logic                               peripheral_power_req_1_o,
  output logic                               peripheral_power_req_2_o,
  output logic                               reset_request_in_o,
  output logic                               warm_reset_in_n_o,
  output logic                               bus_supply_detect_in_o,
  output logic                               converter_clock_sync_in_o,
  output logic                               keep_alive_in_o,
  output logic                               sleep_request_in_n_o
);

  import gpio_port_pkg::*;

  //////////////////////////////////////////////////////////////////////////////

  func_sel_t  func_sel [LINES];
  logic [LINES-1:0] gpio_mode;
  logic [LINES-1:0] deb_level;
  logic [LINES-1:0] evt_hit;
  logic [LINES-1:0] line_status;
  logic [LINES-1:0] arm;

  logic [LINES-1:0] out_q,      out_d;
  logic [LINES-1:0] data_in_q,  data_in_d;
  logic [LINES-1:0] pad_out_q,  pad_out_d;
  logic [LINES-1:0] pad_oe_q,   pad_oe_d;
  logic [LINES-1:0] pull_up_q,  pull_up_d;
  logic [LINES-1:0] pull_dn_q,  pull_dn_d;
  logic [LINES-1:0] wake_q;
  logic [LINES-1:0] on_req_q;
  logic [8:0]       alt_in_q,   alt_in_d;
  logic [1:0]       port_in_q,  port_in_d;

  //////////////////////////////////////////////////////////////////////////////
  // Function selection and per-line helpers.

  genvar gi;
  generate
    for (gi = 0; gi < LINES; gi++)
    begin : g_line
      if (gi < SEL_A_LINES)
      begin : g_sel_a
        assign func_sel[gi] = pad_function_select_a_i[gi*FUNC_W +: FUNC_W];
      end
      else
      begin : g_sel_b
        assign func_sel[gi] = pad_function_select_b_i[(gi-SEL_A_LINES)*FUNC_W +: FUNC_W];
      end

      assign gpio_mode[gi] = (func_sel[gi] == FN_GPIO);
      // Detection only runs in general-purpose mode, enabled and unmasked.
      assign arm[gi] = gpio_mode[gi] & gpio_global_enable_i & ~irq_mask_i[gi];

      line_debounce #(
        .CYCLES (DEB_CYCLES)
      ) u_debounce (
        .core_clk_i (core_clk_i),
        .reset_i    (reset_i),
        .raw_i      (pad_in_i[gi]),
        .enable_i   (line_debounce_enable_i[gi]),
        .level_o    (deb_level[gi])
      );

      line_event u_event (
        .core_clk_i (core_clk_i),
        .reset_i    (reset_i),
        .level_i    (deb_level[gi]),
        .rise_en_i  (edge_rise_en_i[gi]),
        .fall_en_i  (edge_fall_en_i[gi]),
        .arm_i      (arm[gi]),
        .clear_i    (irq_clear_i[gi]),
        .event_o    (evt_hit[gi]),
        .status_o   (line_status[gi])
      );
    end
  endgenerate

  //////////////////////////////////////////////////////////////////////////////
  // Output data register with write, set and clear strobes.

  always_comb
  begin
    out_d = out_q;
    if (out_write_i)
    begin
      out_d = out_wdata_i;
    end
    if (out_set_i)
    begin
      out_d = out_d | out_set_bits_i;
    end
    if (out_clear_i)
    begin
      out_d = out_d & ~out_clear_bits_i;
    end
  end

  always_ff @(posedge core_clk_i)
  begin
    if (reset_i)
    begin
      out_q <= OUT_RESET;
    end
    else
    begin
      out_q <= out_d;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Pad drive: general-purpose controls or the alternate function per line.

  always_comb
  begin
    for (int i = 0; i < LINES; i++)
    begin
      if (gpio_mode[i])
      begin
        // Global disable releases the pad and its pulls.
        pull_up_d[i] = gpio_global_enable_i & line_pull_config_a_i[i];
        pull_dn_d[i] = gpio_global_enable_i & line_pull_config_b_i[i];
        if (line_open_drain_enable_i[i])
        begin
          pad_out_d[i] = 1'b0;
          pad_oe_d[i]  = gpio_global_enable_i & line_direction_i[i] & ~out_q[i];
        end
        else
        begin
          pad_out_d[i] = out_q[i];
          pad_oe_d[i]  = gpio_global_enable_i & line_direction_i[i];
        end
      end
      else
      begin
        pull_up_d[i] = alt_pull_up_i[i];
        pull_dn_d[i] = alt_pull_down_i[i];
        pad_out_d[i] = 1'b0;
        pad_oe_d[i]  = 1'b0;
      end
    end

    // Alternate outputs; each is a push-pull drive unless its open-drain bit is set.
    if (func_sel[0] == FN_ALT3)
    begin
      pad_out_d[0] = ext_regulator_on_1_i;
      pad_oe_d[0]  = 1'b1;
    end
    if (func_sel[2] == FN_ALT1)
    begin
      pad_out_d[2] = scaling_port_data_out_i;
      pad_oe_d[2]  = scaling_port_data_oe_i;
    end
    if (func_sel[3] == FN_ALT1)
    begin
      pad_out_d[3] = ext_regulator_on_1_i;
      pad_oe_d[3]  = 1'b1;
    end
    if (func_sel[4] == FN_ALT1)
    begin
      pad_out_d[4] = ext_regulator_on_2_i;
      pad_oe_d[4]  = 1'b1;
    end
    else if (func_sel[4] == FN_ALT2)
    begin
      pad_out_d[4] = scaling_port_clock_select_out_i;
      pad_oe_d[4]  = scaling_port_clock_select_oe_i;
    end
    if (func_sel[5] == FN_ALT2)
    begin
      pad_out_d[5] = ext_regulator_on_3_i;
      pad_oe_d[5]  = 1'b1;
    end
    if (func_sel[6] == FN_ALT2)
    begin
      pad_out_d[6] = supplies_valid_out_i;
      pad_oe_d[6]  = 1'b1;
    end
    else if (func_sel[6] == FN_ALT3)
    begin
      pad_out_d[6] = ext_regulator_on_3_i;
      pad_oe_d[6]  = 1'b1;
    end

    for (int i = 0; i < LINES; i++)
    begin
      if (!gpio_mode[i] && alt_open_drain_i[i] && pad_oe_d[i])
      begin
        pad_oe_d[i]  = ~pad_out_d[i];
        pad_out_d[i] = 1'b0;
      end
    end
  end

  always_ff @(posedge core_clk_i)
  begin
    if (reset_i)
    begin
      pad_out_q <= '0;
      pad_oe_q  <= '0;
      pull_up_q <= '0;
      pull_dn_q <= '0;
    end
    else
    begin
      pad_out_q <= pad_out_d;
      pad_oe_q  <= pad_oe_d;
      pull_up_q <= pull_up_d;
      pull_dn_q <= pull_dn_d;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Alternate inputs; an unselected active-low input idles high.

  always_comb
  begin
    alt_in_d[0] = (func_sel[0] == FN_ALT1) & pad_in_i[0];
    alt_in_d[1] = (func_sel[1] == FN_ALT4) & pad_in_i[1];
    alt_in_d[2] = ((func_sel[0] == FN_ALT2) & pad_in_i[0])
                | ((func_sel[2] == FN_ALT2) & pad_in_i[2]);
    alt_in_d[3] = (func_sel[1] == FN_ALT1) & pad_in_i[1];
    alt_in_d[4] = (func_sel[1] != FN_ALT2) | pad_in_i[1];
    alt_in_d[5] = (func_sel[1] == FN_ALT3) & pad_in_i[1];
    alt_in_d[6] = (func_sel[3] == FN_ALT2) & pad_in_i[3];
    alt_in_d[7] = (func_sel[5] == FN_ALT1) & pad_in_i[5];
    alt_in_d[8] = (func_sel[6] != FN_ALT1) | pad_in_i[6];
    port_in_d[0] = (func_sel[2] == FN_ALT1) ? pad_in_i[2] : 1'b1;
    port_in_d[1] = (func_sel[4] == FN_ALT2) ? pad_in_i[4] : 1'b1;
  end

  always_ff @(posedge core_clk_i)
  begin
    if (reset_i)
    begin
      alt_in_q  <= 9'h110;
      port_in_q <= 2'h3;
    end
    else
    begin
      alt_in_q  <= alt_in_d;
      port_in_q <= port_in_d;
    end
  end

  assign power_off_request_in_o         = alt_in_q[0];
  assign peripheral_power_req_1_o       = alt_in_q[1];
  assign peripheral_power_req_2_o       = alt_in_q[2];
  assign reset_request_in_o             = alt_in_q[3];
  assign warm_reset_in_n_o              = alt_in_q[4];
  assign bus_supply_detect_in_o         = alt_in_q[5];
  assign converter_clock_sync_in_o      = alt_in_q[6];
  assign keep_alive_in_o                = alt_in_q[7];
  assign sleep_request_in_n_o           = alt_in_q[8];
  assign scaling_port_data_in_o         = port_in_q[0];
  assign scaling_port_clock_select_in_o = port_in_q[1];

  //////////////////////////////////////////////////////////////////////////////
  // Input readback, wake and switch-on requests.

  assign data_in_d = deb_level & ~line_direction_i & gpio_mode;

  always_ff @(posedge core_clk_i)
  begin
    if (reset_i)
    begin
      data_in_q <= '0;
    end
    else
    begin
      data_in_q <= data_in_d;
    end
  end

  always_ff @(posedge core_clk_i)
  begin
    if (reset_i)
    begin
      wake_q   <= '0;
      on_req_q <= '0;
    end
    else
    begin
      wake_q   <= evt_hit;
      on_req_q <= evt_hit & ON_REQ_CAPABLE;
    end
  end

  assign pad_out_o       = pad_out_q;
  assign pad_oe_o        = pad_oe_q;
  assign pad_pull_up_o   = pull_up_q;
  assign pad_pull_down_o = pull_dn_q;
  assign line_data_out_o = out_q;
  assign line_data_in_o  = data_in_q;
  assign irq_status_o    = line_status;
  assign irq_o           = |line_status;
  assign wake_event_o    = wake_q;
  assign on_request_o    = on_req_q;

  //////////////////////////////////////////////////////////////////////////////
  // Checks.

  chk_set_bits_only: assert property (@(posedge core_clk_i) disable iff (reset_i)
    (out_set_i && !out_write_i && !out_clear_i) |=> (out_q == ($past(out_q) | $past(out_set_bits_i))))
    else $error("set strobe changed an unselected output bit");

  chk_clear_bits_only: assert property (@(posedge core_clk_i) disable iff (reset_i)
    (out_clear_i && !out_write_i && !out_set_i) |=> (out_q == ($past(out_q) & ~$past(out_clear_bits_i))))
    else $error("clear strobe changed an unselected output bit");

  chk_alt_no_irq: assert property (@(posedge core_clk_i) disable iff (reset_i)
    (evt_hit & ~gpio_mode) == '0)
    else $error("alternate-mode line raised an event");

  chk_masked_no_irq: assert property (@(posedge core_clk_i) disable iff (reset_i)
    (irq_mask_i & ~line_status) != '0 |=> ((irq_status_o & ~$past(line_status) & $past(irq_mask_i)) == '0))
    else $error("masked line recorded an event");

  chk_no_io_on_req: assert property (@(posedge core_clk_i) disable iff (reset_i)
    (on_request_o & ~ON_REQ_CAPABLE) == '0)
    else $error("I/O-supply line produced a switch-on request");

  chk_gpio_disable: assert property (@(posedge core_clk_i) disable iff (reset_i)
    !gpio_global_enable_i |=> ((pad_oe_o & $past(gpio_mode)) == '0))
    else $error("disabled port still drives a pad");

  chk_regulator_line3: assert property (@(posedge core_clk_i) disable iff (reset_i)
    (func_sel[3] == FN_ALT1 && !alt_open_drain_i[3]) |=> (pad_oe_o[3] && pad_out_o[3] == $past(ext_regulator_on_1_i)))
    else $error("regulator enable not driven on line 3");

  chk_alt_pulls: assert property (@(posedge core_clk_i) disable iff (reset_i)
    !gpio_mode[0] |=> (pad_pull_up_o[0] == $past(alt_pull_up_i[0])))
    else $error("alternate pull setting not applied");

endmodule : pmic_gpio_mux_port

//--- board_pads.sv
`timescale 1ns/1ps

// Board side of the pads: external drivers, pulls, and a floating pad that never holds a level.
module board_pads
(
  input  wire logic       core_clk_i,
  input  wire logic [6:0] drv_i,
  input  wire logic [6:0] oe_i,
  input  wire logic [6:0] pu_i,
  input  wire logic [6:0] pd_i,
  input  wire logic [6:0] ext_i,
  input  wire logic [6:0] ext_en_i,
  output logic      [6:0] pad_o
);
  logic [6:0] float_q = 7'h55;

  always_ff @(posedge core_clk_i) float_q <= ~float_q;

  always_comb
    for (int i = 0; i < 7; i++)
      pad_o[i] = ext_en_i[i] ? ext_i[i] : oe_i[i] ? drv_i[i] : pu_i[i] ? 1'b1 : pd_i[i] ? 1'b0 : float_q[i];
endmodule : board_pads

//--- pmic_gpio_mux_port_bench.sv
`timescale 1ns/1ps

`define CHK(n, e, a) begin n_checks++; if ((a) !== (e)) begin mismatches++; $display("[ERR] %s exp %0h got %0h", n, e, a); end end

module pmic_gpio_mux_port_bench;
  import gpio_port_pkg::*;
  logic core_clk_i, reset_i, gpio_global_enable_i, out_write_i, out_set_i, out_clear_i, irq_o;
  logic ext_regulator_on_1_i, ext_regulator_on_2_i, ext_regulator_on_3_i, supplies_valid_out_i;
  logic scaling_port_data_out_i, scaling_port_data_oe_i, scaling_port_data_in_o;
  logic scaling_port_clock_select_out_i, scaling_port_clock_select_oe_i, scaling_port_clock_select_in_o;
  logic power_off_request_in_o, peripheral_power_req_1_o, peripheral_power_req_2_o, reset_request_in_o;
  logic warm_reset_in_n_o, bus_supply_detect_in_o, converter_clock_sync_in_o, keep_alive_in_o;
  logic sleep_request_in_n_o;
  line_vec_t pad_in_i, pad_out_o, pad_oe_o, pad_pull_up_o, pad_pull_down_o, line_direction_i;
  line_vec_t line_debounce_enable_i, line_pull_config_a_i, line_pull_config_b_i, line_open_drain_enable_i;
  line_vec_t alt_pull_up_i, alt_pull_down_i, alt_open_drain_i, out_wdata_i, out_set_bits_i, out_clear_bits_i;
  line_vec_t line_data_out_o, line_data_in_o, edge_rise_en_i, edge_fall_en_i, irq_mask_i, irq_clear_i;
  line_vec_t irq_status_o, wake_event_o, on_request_o, ext_drv, ext_en;
  logic [11:0] pad_function_select_a_i;
  logic [8:0]  pad_function_select_b_i;
  int seed = 32'h0A263F16;
  int mismatches = 0;
  int n_checks = 0;
  int exp_out, prev;

  pmic_gpio_mux_port #(.DEB_CYCLES(4)) dut (.*);
  board_pads board (.core_clk_i(core_clk_i), .drv_i(pad_out_o), .oe_i(pad_oe_o), .pu_i(pad_pull_up_o),
                    .pd_i(pad_pull_down_o), .ext_i(ext_drv), .ext_en_i(ext_en), .pad_o(pad_in_i));

  initial
  begin
    core_clk_i = 1'b0;
    forever #5 core_clk_i = ~core_clk_i;
  end

  //////////////////////////////////////////////////////////////////////////////
  task automatic step();
    @(posedge core_clk_i);
    #1;
  endtask : step

  task automatic stop_test();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : stop_test

  // Clears status, drives a new pad level and collects what the port reports.
  task automatic edge_test(input line_vec_t rise, input line_vec_t fall, input line_vec_t lvl, input line_vec_t st);
    line_vec_t w, r;
    edge_rise_en_i = rise;
    edge_fall_en_i = fall;
    irq_clear_i = 7'h7F;
    step();
    irq_clear_i = 7'h00;
    step();
    `CHK("status_clr", 7'h00, irq_status_o)
    ext_drv = lvl;
    w = 7'h00;
    r = 7'h00;
    repeat (5)
    begin
      step();
      w |= wake_event_o;
      r |= on_request_o;
    end
    `CHK("status", st, irq_status_o)
    `CHK("wake", st, w)
    `CHK("on_req", st & ON_REQ_CAPABLE, r)
    `CHK("irq", st != 7'h00, irq_o)
  endtask : edge_test

  initial
  begin
    #20000;
    mismatches++;
    stop_test();
  end

  //////////////////////////////////////////////////////////////////////////////
  initial
  begin
    reset_i = 1'b1;
    {gpio_global_enable_i, out_write_i, out_set_i, out_clear_i, ext_regulator_on_1_i} = '0;
    {ext_regulator_on_2_i, ext_regulator_on_3_i, supplies_valid_out_i, scaling_port_data_out_i} = '0;
    {scaling_port_data_oe_i, scaling_port_clock_select_out_i, scaling_port_clock_select_oe_i} = '0;
    {line_direction_i, line_debounce_enable_i, line_pull_config_a_i, line_pull_config_b_i} = '0;
    {line_open_drain_enable_i, alt_pull_up_i, alt_pull_down_i, alt_open_drain_i, out_wdata_i} = '0;
    {out_set_bits_i, out_clear_bits_i, edge_rise_en_i, edge_fall_en_i, irq_mask_i, irq_clear_i} = '0;
    {ext_drv, ext_en, pad_function_select_a_i, pad_function_select_b_i} = '0;
    repeat (2) @(posedge core_clk_i);
    #1;
    reset_i = 1'b0;
    `CHK("data_out_rst", 7'h00, line_data_out_o)
    `CHK("warm_n_rst", 1'b1, warm_reset_in_n_o)
    `CHK("sleep_n_rst", 1'b1, sleep_request_in_n_o)
    `CHK("req_rst", 2'h0, {peripheral_power_req_1_o, peripheral_power_req_2_o})
    `CHK("off_rst", 2'h0, {power_off_request_in_o, reset_request_in_o})
    `CHK("sense_rst", 2'h0, {bus_supply_detect_in_o, converter_clock_sync_in_o})
    `CHK("port_rst", 2'h3, {scaling_port_data_in_o, scaling_port_clock_select_in_o})
    line_direction_i = 7'h7F;
    gpio_global_enable_i = 1'b1;
    exp_out = 0;
    prev = 0;
    step();
    step();
    for (int k = 0; k < 24; k++)
    begin
      {out_write_i, out_set_i, out_clear_i} = 3'($random(seed));
      out_wdata_i = 7'($random(seed));
      out_set_bits_i = 7'($random(seed));
      out_clear_bits_i = 7'($random(seed));
      line_open_drain_enable_i = 7'($random(seed));
      if (out_write_i) exp_out = out_wdata_i;
      if (out_set_i) exp_out |= out_set_bits_i;
      if (out_clear_i) exp_out &= ~int'(out_clear_bits_i);
      step();
      `CHK("data_out", line_vec_t'(exp_out), line_data_out_o)
      `CHK("pad_out", line_vec_t'(prev) & ~line_open_drain_enable_i, pad_out_o)
      `CHK("pad_oe", ~(line_vec_t'(prev) & line_open_drain_enable_i), pad_oe_o)
      prev = exp_out;
    end
    {out_write_i, out_set_i, out_clear_i} = 3'h0;
    line_direction_i = 7'h00;
    ext_en = 7'h7F;
    irq_mask_i = 7'h10;
    pad_function_select_b_i = 9'h008;
    repeat (4) step();
    edge_test(7'h7F, 7'h00, 7'h7F, 7'h4F);
    `CHK("data_in", 7'h5F, line_data_in_o)
    `CHK("keep_alive", 1'b1, keep_alive_in_o)
    edge_test(7'h00, 7'h7F, 7'h00, 7'h4F);
    gpio_global_enable_i = 1'b0;
    edge_test(7'h7F, 7'h00, 7'h7F, 7'h00);
    gpio_global_enable_i = 1'b1;
    // A two-cycle glitch must be filtered; a level held well past the debounce time must get through.
    line_debounce_enable_i = 7'h7F;
    ext_drv = 7'h00;
    repeat (2) step();
    ext_drv = 7'h7F;
    repeat (8) step();
    `CHK("glitch", 7'h00, irq_status_o)
    ext_drv = 7'h00;
    repeat (10) step();
    ext_drv = 7'h7F;
    repeat (10) step();
    `CHK("debounced", 7'h4F, irq_status_o)
    pad_function_select_a_i = 12'h299;
    pad_function_select_b_i = 9'h042;
    scaling_port_clock_select_oe_i = 1'b1;
    for (int k = 0; k < 6; k++)
    begin
      ext_regulator_on_1_i = 1'($random(seed));
      ext_drv = 7'($random(seed));
      line_direction_i = 7'($random(seed));
      alt_pull_up_i = 7'($random(seed));
      alt_pull_down_i = 7'($random(seed));
      line_pull_config_a_i = 7'($random(seed));
      scaling_port_clock_select_out_i = 1'($random(seed));
      step();
      step();
      `CHK("pull_up", (alt_pull_up_i & 7'h5F) | (line_pull_config_a_i & 7'h20), pad_pull_up_o)
      `CHK("pull_dn", alt_pull_down_i & 7'h5F, pad_pull_down_o)
      `CHK("power_off", ext_drv[0], power_off_request_in_o)
      `CHK("bus_detect", ext_drv[1], bus_supply_detect_in_o)
      `CHK("req2", ext_drv[2], peripheral_power_req_2_o)
      `CHK("sel_in", ext_drv[4], scaling_port_clock_select_in_o)
      `CHK("sel_pad", scaling_port_clock_select_out_i, pad_out_o[4])
      `CHK("reg1_pad", ext_regulator_on_1_i, pad_out_o[3])
      `CHK("reg1_oe", 1'b1, pad_oe_o[3])
      `CHK("sleep_n", ext_drv[6], sleep_request_in_n_o)
    end
    stop_test();
  end
endmodule : pmic_gpio_mux_port_bench
